/* File: core/trp.sv */
package trp;
  // ==========================================================
  // geometry: five channels, pins A (even) and B (odd)
  localparam int NUM_PINS = 10;
  localparam int NUM_CH   = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] OFS_MODE     = 5'h00;
  localparam logic [4:0] OFS_START    = 5'h04;
  localparam logic [4:0] OFS_PIN_IO   = 5'h08;
  localparam logic [4:0] OFS_OUT_EN   = 5'h0C;
  localparam logic [4:0] OFS_LEVEL    = 5'h10;
  localparam logic [4:0] OFS_PIN_FUNC = 5'h14;
  localparam logic [4:0] OFS_STATUS   = 5'h18;

  // ==========================================================
  // field positions
  localparam int PIO_ACT_POS  = 10;  // 2 bits per pin above the init levels
  localparam int PF_PEN_POS   = 10;  // port output enables
  localparam int PF_PDAT_POS  = 20;  // port output data
  localparam int ST_RUN_POS   = 10;
  localparam int LV_POS_BIT   = 0;
  localparam int LV_NEG_BIT   = 1;
  localparam int FIRST_CH34   = 6;   // out-enable bit 0 maps to this pin

  // ==========================================================
  // pin groups and reset values
  localparam logic [9:0] POS_PINS  = 10'h140;
  localparam logic [9:0] NEG_PINS  = 10'h280;
  localparam logic [9:0] CH34_PINS = 10'h3C0;
  localparam logic [9:0] RST_OUT   = 10'h000;
  localparam logic [9:0] RST_OE_N  = 10'h3FF;

  // ==========================================================
  // match actions
  localparam logic [1:0] ACT_HOLD   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_PWM1, MODE_PWM2, MODE_PHASE, MODE_COMP, MODE_RSYNC
  } mode_e;

  typedef struct packed {
    logic       force_lvl;
    logic       load;
    logic       lvl;
    logic       hit;
    logic [1:0] act;
  } pin_cmd_s;

  typedef struct packed {
    logic [9:0] out;
    logic [9:0] oe_n;
  } pad_s;
endpackage

/* File: core/pin_level_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_level_gen (
  input  wire logic          i_clk,
  input  wire trp::pin_cmd_s i_cmd,
  input  wire logic          i_nrst,
  output logic               o_level
);
  // ==========================================================
  // next level: forced or loaded level beats a match event
  logic next_level;
  always_comb begin
    next_level = o_level;
    if (i_cmd.force_lvl || i_cmd.load) begin
      next_level = i_cmd.lvl;
    end else if (i_cmd.hit) begin
      case (i_cmd.act)
        trp::ACT_LOW:    next_level = 1'b0;
        trp::ACT_HIGH:   next_level = 1'b1;
        trp::ACT_TOGGLE: next_level = ~o_level;
        default:         next_level = o_level;
      endcase
    end
  end

  // ==========================================================
  // waveform output is low out of reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= 1'b0;
    end else begin
      o_level <= next_level;
    end
  end
endmodule
`default_nettype wire

/* File: core/pin_recovery_ctrl.sv */
// Summary of operation
// - after reset waveform outputs low, pads undriven until function selected
// - pin set high with low-on-match goes low at the match
// - pwm mode 1 pin control write leaves B-side pins untouched
// - pwm mode 2 pin control write leaves cycle-register pins untouched
// - stopping in complementary pwm restores its configured initial levels
// - complementary pwm to normal or pwm mode 1 drives outputs low
// - stopping in reset-synchronous pwm restores its configured initial levels
// - reset-synchronous pwm to normal: positive phase low, negative phase high
// - complementary pwm running toggles complementary pairs at matches
// - reset-synchronous pwm running sets active at match, restores at cycle
// - phase counting serves channels 1 and 2 only, no ch 3/4 enable use
// - pwm mode 2 serves channels 0 to 2 only, no ch 3/4 enable use
`timescale 1ns/10ps
`default_nettype none
module pin_recovery_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [9:0]  i_match,
  input  wire logic        i_cycle_start,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic      [9:0]  o_timer_out,
  output trp::pad_s        o_pad,
  output logic             o_running
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // channel may take match events in this mode
  function automatic logic chan_ok(input trp::mode_e m, input int ch);
    case (m)
      trp::MODE_PHASE: chan_ok = (ch == 1) || (ch == 2);
      trp::MODE_PWM2:  chan_ok = (ch <= 2);
      trp::MODE_COMP,
      trp::MODE_RSYNC: chan_ok = 1'b0;
      default:         chan_ok = 1'b1;
    endcase
  endfunction

  // pin may take an initial level from the pin control write
  function automatic logic init_ok(input trp::mode_e m, input int pin);
    case (m)
      trp::MODE_PWM1:  init_ok = (pin % 2) == 0;
      trp::MODE_PWM2:  init_ok = ((pin % 2) == 1) && chan_ok(m, pin / 2);
      trp::MODE_PHASE: init_ok = chan_ok(m, pin / 2);
      trp::MODE_COMP,
      trp::MODE_RSYNC: init_ok = !(trp::POS_PINS[pin] || trp::NEG_PINS[pin]);
      default:         init_ok = 1'b1;
    endcase
  endfunction

  // ==========================================================
  // bus decode; a write lands on the edge that samples ack high
  wire logic req    = i_wb_cyc && i_wb_stb;
  wire logic wr_now = req && i_wb_we && o_wb_ack;
  wire logic wr_mode = wr_now && (i_wb_adr == trp::OFS_MODE);
  wire logic wr_start = wr_now && (i_wb_adr == trp::OFS_START);
  wire logic wr_pio = wr_now && (i_wb_adr == trp::OFS_PIN_IO);
  wire logic wr_oen = wr_now && (i_wb_adr == trp::OFS_OUT_EN);
  wire logic wr_lvl = wr_now && (i_wb_adr == trp::OFS_LEVEL);
  wire logic wr_pf  = wr_now && (i_wb_adr == trp::OFS_PIN_FUNC);

  trp::mode_e  mode;
  logic [29:0] pio;
  logic [3:0]  out_en;
  logic [1:0]  lvl_ctrl;
  logic [29:0] pin_func;

  wire logic [31:0] wdat_mode = merge({29'h0, mode}, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdat_pio  = merge({2'h0, pio}, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdat_oen  = merge({28'h0, out_en}, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdat_lvl  = merge({30'h0, lvl_ctrl}, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdat_pf   = merge({2'h0, pin_func}, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdat_st   = merge({31'h0, o_running}, i_wb_dat, i_wb_sel);
  // codes above the last mode are ignored rather than stored
  wire logic        mode_valid = wdat_mode[2:0] <= 3'(trp::MODE_RSYNC);
  wire trp::mode_e  new_mode = trp::mode_e'(wdat_mode[2:0]);

  // ==========================================================
  // events that fix levels
  wire logic pair_mode  = (mode == trp::MODE_COMP) || (mode == trp::MODE_RSYNC);
  wire logic stop_ev    = wr_start && o_running && !wdat_st[0];
  wire logic to_plain   = wr_mode && mode_valid &&
                          ((new_mode == trp::MODE_NORMAL) || (new_mode == trp::MODE_PWM1));
  wire logic leave_comp = to_plain && (mode == trp::MODE_COMP);
  wire logic leave_rsyn = to_plain && (mode == trp::MODE_RSYNC);
  wire logic rsyn_cycle = o_running && (mode == trp::MODE_RSYNC) && i_cycle_start;
  // ch 3/4 enables only matter in modes that use those channels
  wire logic ch34_free  = (mode == trp::MODE_PWM2) || (mode == trp::MODE_PHASE);

  logic [9:0] level;
  logic [9:0] timer_drive;

  // ==========================================================
  // per-pin command build and level flop
  for (genvar g = 0; g < trp::NUM_PINS; g++) begin : g_pin
    localparam int PAIR = g - (g % 2);
    localparam logic IN_PAIR = trp::POS_PINS[g] | trp::NEG_PINS[g];
    wire logic       init_lvl = trp::POS_PINS[g] ? lvl_ctrl[trp::LV_POS_BIT]
                                                : lvl_ctrl[trp::LV_NEG_BIT];
    wire logic       pair_run = IN_PAIR && pair_mode;
    wire logic       f_init = pair_run && (stop_ev || rsyn_cycle);
    wire logic       f_leave = leave_comp || leave_rsyn;
    wire logic [1:0] rsyn_act = init_lvl ? trp::ACT_LOW : trp::ACT_HIGH;
    trp::pin_cmd_s   cmd;
    assign cmd.force_lvl = f_init || f_leave;
    assign cmd.lvl = f_init ? init_lvl :
                     f_leave ? (leave_rsyn && trp::NEG_PINS[g]) : wdat_pio[g];
    assign cmd.load = wr_pio && init_ok(mode, g);
    assign cmd.hit = o_running && (pair_run ? i_match[PAIR] :
                                   (i_match[g] && chan_ok(mode, g / 2)));
    assign cmd.act = !pair_run ? pio[trp::PIO_ACT_POS + 2*g +: 2] :
                     (mode == trp::MODE_COMP) ? trp::ACT_TOGGLE : rsyn_act;
    if (g >= trp::FIRST_CH34) begin : g_ch34
      assign timer_drive[g] = pin_func[g] && (out_en[g - trp::FIRST_CH34] || ch34_free);
    end else begin : g_low
      assign timer_drive[g] = pin_func[g];
    end
    pin_level_gen u_lvl (
      .i_clk   (i_clk),
      .i_cmd   (cmd),
      .i_nrst  (i_nrst),
      .o_level (level[g])
    );
  end
  assign o_timer_out = level;

  // ==========================================================
  // control registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode      <= trp::MODE_NORMAL;
      o_running <= 1'b0;
      pio       <= 30'h0;
      out_en    <= 4'h0;
      lvl_ctrl  <= 2'h0;
      pin_func  <= 30'h0;
    end else begin
      if (wr_mode && mode_valid) mode <= new_mode;
      if (wr_start) o_running <= wdat_st[0];
      if (wr_pio) pio <= wdat_pio[29:0];
      if (wr_oen) out_en <= wdat_oen[3:0];
      if (wr_lvl) lvl_ctrl <= wdat_lvl[1:0];
      if (wr_pf) pin_func <= wdat_pf[29:0];
    end
  end

  // ==========================================================
  // pad drive: timer level, port data, or released
  wire logic [9:0] port_en   = pin_func[trp::PF_PEN_POS +: 10];
  wire logic [9:0] port_dat  = pin_func[trp::PF_PDAT_POS +: 10];
  wire logic [9:0] next_out  = (timer_drive & level) | (~timer_drive & port_dat);
  wire logic [9:0] next_oe_n = ~(timer_drive | port_en);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pad.out  <= trp::RST_OUT;
      o_pad.oe_n <= trp::RST_OE_N;
    end else begin
      o_pad.out  <= next_out;
      o_pad.oe_n <= next_oe_n;
    end
  end

  // ==========================================================
  // read mux; unmapped offsets read zero and still ack
  logic [31:0] rd_mux;
  always_comb begin
    case (i_wb_adr)
      trp::OFS_MODE:     rd_mux = {29'h0, mode};
      trp::OFS_START:    rd_mux = {31'h0, o_running};
      trp::OFS_PIN_IO:   rd_mux = {2'h0, pio};
      trp::OFS_OUT_EN:   rd_mux = {28'h0, out_en};
      trp::OFS_LEVEL:    rd_mux = {30'h0, lvl_ctrl};
      trp::OFS_PIN_FUNC: rd_mux = {2'h0, pin_func};
      trp::OFS_STATUS:   rd_mux = {21'h0, o_running, level};
      default:           rd_mux = 32'h0;
    endcase
  end

  // one wait state: ack the cycle after the request, drop it next
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= req && !o_wb_ack;
      if (req && !o_wb_ack) o_wb_dat <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  logic any_wr;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      any_wr <= 1'b0;
    end else if (wr_now) begin
      any_wr <= 1'b1;
    end
  end

  sequence s_req_new;
    req && !o_wb_ack;
  endsequence
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_ack;
    @(posedge i_clk) disable iff (!i_nrst)
    s_req_new |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");

  property p_reset_out;
    @(posedge i_clk) disable iff (!i_nrst)
    !any_wr |-> (o_timer_out == 10'h000) && (o_pad.oe_n == 10'h3FF);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle");

  property p_match_low;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_NORMAL && i_match[0] && !wr_now &&
     pio[trp::PIO_ACT_POS +: 2] == trp::ACT_LOW) |=> !o_timer_out[0];
  endproperty
  a_match_low: assert property (p_match_low) else $error("no low on match");

  property p_pwm1_b;
    @(posedge i_clk) disable iff (!i_nrst)
    (wr_pio && mode == trp::MODE_PWM1 && !o_running) |=>
      (o_timer_out[1] == $past(o_timer_out[1])) && (o_timer_out[0] == $past(wdat_pio[0]));
  endproperty
  a_pwm1_b: assert property (p_pwm1_b) else $error("b pin initialised");

  property p_pwm2_cyc;
    @(posedge i_clk) disable iff (!i_nrst)
    (wr_pio && mode == trp::MODE_PWM2 && !o_running) |=>
      (o_timer_out[0] == $past(o_timer_out[0])) && (o_timer_out[1] == $past(wdat_pio[1]));
  endproperty
  a_pwm2_cyc: assert property (p_pwm2_cyc) else $error("cycle pin initialised");

  property p_comp_stop;
    @(posedge i_clk) disable iff (!i_nrst)
    (stop_ev && mode == trp::MODE_COMP) |=>
      (o_timer_out[6] == lvl_ctrl[0]) && (o_timer_out[7] == lvl_ctrl[1]);
  endproperty
  a_comp_stop: assert property (p_comp_stop) else $error("comp stop level");

  property p_comp_exit;
    @(posedge i_clk) disable iff (!i_nrst)
    leave_comp |=> (o_timer_out == 10'h000) ##1 !o_running;
  endproperty
  a_comp_exit: assert property (p_comp_exit) else $error("comp exit not low");

  property p_rsyn_stop;
    @(posedge i_clk) disable iff (!i_nrst)
    (stop_ev && mode == trp::MODE_RSYNC) |=>
      (o_timer_out[8] == lvl_ctrl[0]) && (o_timer_out[9] == lvl_ctrl[1]);
  endproperty
  a_rsyn_stop: assert property (p_rsyn_stop) else $error("rsync stop level");

  property p_rsyn_exit;
    @(posedge i_clk) disable iff (!i_nrst)
    leave_rsyn |=> ((o_timer_out & trp::POS_PINS) == 10'h000) &&
                   ((o_timer_out & trp::NEG_PINS) == trp::NEG_PINS);
  endproperty
  a_rsyn_exit: assert property (p_rsyn_exit) else $error("rsync exit levels");

  property p_comp_pair;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_COMP && i_match[6] && !wr_now) |=>
      (o_timer_out[6] != $past(o_timer_out[6])) && (o_timer_out[7] != $past(o_timer_out[7]));
  endproperty
  a_comp_pair: assert property (p_comp_pair) else $error("pair not toggled");

  property p_rsyn_set;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_RSYNC && i_match[8] && !i_cycle_start && !wr_now) |=>
      (o_timer_out[8] == !lvl_ctrl[0]) && (o_timer_out[9] == !lvl_ctrl[1]);
  endproperty
  a_rsyn_set: assert property (p_rsyn_set) else $error("rsync not active");

  property p_phase_ch0;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_PHASE && !wr_now) |=>
      (o_timer_out[1:0] == $past(o_timer_out[1:0]));
  endproperty
  a_phase_ch0: assert property (p_phase_ch0) else $error("phase moved ch0");

  property p_pwm2_ch3;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_PWM2 && !wr_now) |=>
      (o_timer_out[9:6] == $past(o_timer_out[9:6]));
  endproperty
  a_pwm2_ch3: assert property (p_pwm2_ch3) else $error("pwm2 moved ch3");

  // pads stay released while neither timer nor port function is chosen
  property p_pad_idle;
    @(posedge i_clk) disable iff (!i_nrst)
    (pin_func[19:0] == 20'h00000) |=> (o_pad.oe_n == 10'h3FF);
  endproperty
  a_pad_idle: assert property (p_pad_idle) else $error("pad driven unselected");

  // cycle start puts the second pair back on its initial levels
  property p_rsyn_cycle;
    @(posedge i_clk) disable iff (!i_nrst)
    (rsyn_cycle && !wr_now) |=>
      (o_timer_out[8] == lvl_ctrl[0]) && (o_timer_out[9] == lvl_ctrl[1]);
  endproperty
  a_rsyn_cycle: assert property (p_rsyn_cycle) else $error("rsync cycle level");

  // second pair follows the match of its positive pin
  property p_comp_pair_b;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_running && mode == trp::MODE_COMP && i_match[8] && !wr_now) |=>
      (o_timer_out[8] != $past(o_timer_out[8])) && (o_timer_out[9] != $past(o_timer_out[9]));
  endproperty
  a_comp_pair_b: assert property (p_comp_pair_b) else $error("pair b not toggled");
endmodule
`default_nettype wire

/* File: verification/sw_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module sw_sequencer (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic      [4:0]  o_adr,
  output logic      [3:0]  o_sel,
  output logic      [31:0] o_dat
);
  int          tmo;
  logic [31:0] rd;

  // ==========================================================
  // classic wishbone master, idle values at time zero
  initial begin
    tmo = 0;
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 5'h1F;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end

  // request held until ack is sampled or 20 cycles pass; released lines show inverted data, never the old value
  task automatic xfer(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_sel <= 4'hF;
    o_dat <= dat;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 20);
    if (i_ack !== 1'b1) tmo++;
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    o_adr <= ~adr;
    o_dat <= ~dat;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask

  task automatic rd_reg(input logic [4:0] adr);
    xfer(1'b0, adr, 32'h0);
  endtask

  task automatic go();
    wr(trp::OFS_PIN_FUNC, 32'h000003FF);
    wr(trp::OFS_START, 32'h00000001);
  endtask

  task automatic park(input logic [9:0] pdat);
    wr(trp::OFS_PIN_FUNC, {2'h0, pdat, 10'h3FF, 10'h000});
    wr(trp::OFS_START, 32'h00000000);
  endtask

  task automatic recover(input trp::mode_e mode, input logic [31:0] pio);
    wr(trp::OFS_MODE, {29'h0, mode});
    // ch 3/4 outputs enabled, else outside pwm mode 2 and phase counting those pads never show the timer level
    wr(trp::OFS_OUT_EN, 32'h0000000F);
    wr(trp::OFS_PIN_IO, pio);
    go();
  endtask

  task automatic enter_pair(input trp::mode_e mode, input logic [1:0] lvl);
    wr(trp::OFS_MODE, {29'h0, trp::MODE_NORMAL});
    wr(trp::OFS_OUT_EN, 32'h0);
    wr(trp::OFS_LEVEL, {30'h0, lvl});
    wr(trp::OFS_MODE, {29'h0, mode});
    wr(trp::OFS_OUT_EN, 32'h0000000F);
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        i_clk;
  logic        i_nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [9:0]  i_match;
  logic        i_cycle_start;
  logic [9:0]  tout;
  trp::pad_s   pad;
  logic        running;
  int          err_total;
  int          compares;
  logic [9:0]  ex;
  logic [9:0]  pd;
  logic [1:0]  lv;
  logic [19:0] ac;
  int          p;

  pin_recovery_ctrl dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .i_match(i_match),
    .i_cycle_start(i_cycle_start), .o_wb_dat(rdat), .o_wb_ack(ack), .o_timer_out(tout),
    .o_pad(pad), .o_running(running));

  sw_sequencer sw (.i_clk(i_clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

  // ==========================================================
  // clock, 25 ns period
  initial i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;

  // expected pair levels: positive pins get lv[0], negative pins lv[1]
  function automatic logic [9:0] pair(input logic [1:0] l);
    return (trp::POS_PINS & {10{l[0]}}) | (trp::NEG_PINS & {10{l[1]}});
  endfunction

  // expected levels after one match on every pin, from the per-pin action codes
  function automatic logic [9:0] act_after(input logic [9:0] l, input logic [19:0] a);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) begin
      case (a[2*i +: 2])
        trp::ACT_LOW:    r[i] = 1'b0;
        trp::ACT_HIGH:   r[i] = 1'b1;
        trp::ACT_TOGGLE: r[i] = ~l[i];
        default:         r[i] = l[i];
      endcase
    end
    return r;
  endfunction

  task automatic check_pins(input string what, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // waits past the two-cycle pad latency so levels are settled
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic pulse(input logic [9:0] m, input logic cs);
    @(posedge i_clk);
    i_match <= m;
    i_cycle_start <= cs;
    @(posedge i_clk);
    i_match <= 10'h000;
    i_cycle_start <= 1'b0;
    settle();
  endtask

  task automatic final_report();
    err_total += sw.tmo;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    err_total = 0;
    compares = 0;
    i_nrst = 1'b0;
    i_match = 10'h000;
    i_cycle_start = 1'b0;
    void'($urandom(46869));
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check_pins("timer_out", trp::RST_OUT, tout);
    check_pins("pad_oe_n", trp::RST_OE_N, pad.oe_n);
    $display("test reset done");

    sw.recover(trp::MODE_PWM1, {2'h0, 20'h55555, 10'h3FF});
    settle();
    check_pins("pwm1 init", 10'h155, tout);
    check_pins("pwm1 pad", 10'h155, pad.out);
    p = 2 * ($urandom % 5);
    pulse(10'h001 << p, 1'b0);
    check_pins("pwm1 match", 10'h155 & ~(10'h001 << p), tout);
    pd = 10'($urandom);
    sw.park(pd);
    settle();
    check_pins("park data", pd, pad.out);
    check_pins("park oe_n", 10'h000, pad.oe_n);
    check_word("running", 32'h0, {31'h0, running});
    $display("test pwm1 done");

    ac = {18'($urandom), trp::ACT_LOW};
    ex = 10'($urandom) | 10'h001;
    sw.recover(trp::MODE_NORMAL, {2'h0, ac, ex});
    settle();
    check_pins("normal init", ex, tout);
    pulse(10'h3FF, 1'b0);
    check_pins("normal match", act_after(ex, ac), tout);
    sw.park(pd);
    $display("test normal done");

    sw.wr(trp::OFS_MODE, {29'h0, trp::MODE_NORMAL});
    sw.wr(trp::OFS_PIN_IO, 32'h0);
    sw.recover(trp::MODE_PWM2, {2'h0, 20'hFFFFF, 10'h3FF});
    settle();
    check_pins("pwm2 init", 10'h02A, tout & 10'h03F);
    pulse(10'h002, 1'b0);
    check_pins("pwm2 toggle", 10'h028, tout & 10'h03F);
    sw.park(pd);
    $display("test pwm2 done");

    sw.recover(trp::MODE_PHASE, {2'h0, 20'h55555, 10'h3FF});
    settle();
    check_pins("phase init", 10'h03C, tout & 10'h03C);
    pulse(10'h005, 1'b0);
    check_pins("phase match", 10'h038, tout & 10'h03C);
    sw.park(pd);
    sw.wr(trp::OFS_PIN_IO, {2'h0, 20'h55555, 10'h3FF});
    sw.go();
    settle();
    check_pins("phase reinit", 10'h03C, tout & 10'h03C);
    sw.park(pd);
    $display("test phase done");

    lv = 2'($urandom);
    ex = pair(lv);
    sw.enter_pair(trp::MODE_COMP, lv);
    sw.go();
    sw.park(pd);
    settle();
    check_pins("comp stop", ex, tout & trp::CH34_PINS);
    sw.go();
    pulse(10'h140, 1'b0);
    check_pins("comp match", ex ^ 10'h3C0, tout & trp::CH34_PINS);
    sw.park(pd);
    settle();
    check_pins("comp restop", ex, tout & trp::CH34_PINS);
    sw.wr(trp::OFS_MODE, {29'h0, trp::MODE_NORMAL});
    settle();
    check_pins("comp exit", 10'h000, tout);
    $display("test comp done");

    lv = 2'($urandom);
    ex = pair(lv);
    sw.enter_pair(trp::MODE_RSYNC, lv);
    sw.go();
    pulse(10'h100, 1'b0);
    check_pins("rsync match", ~ex & 10'h300, tout & 10'h300);
    pulse(10'h000, 1'b1);
    check_pins("rsync cycle", ex, tout & trp::CH34_PINS);
    pulse(10'h100, 1'b0);
    sw.park(pd);
    settle();
    check_pins("rsync stop", ex, tout & trp::CH34_PINS);
    sw.wr(trp::OFS_MODE, {29'h0, trp::MODE_NORMAL});
    settle();
    check_pins("rsync exit", trp::NEG_PINS, tout & trp::CH34_PINS);
    $display("test rsync done");

    sw.rd_reg(5'h1C);
    check_word("unmapped", 32'h0, sw.rd);
    sw.wr(trp::OFS_MODE, 32'h00000006);
    sw.rd_reg(trp::OFS_MODE);
    check_word("mode code 6", {29'h0, trp::MODE_NORMAL}, sw.rd & 32'h7);
    sw.rd_reg(trp::OFS_STATUS);
    check_word("status", {22'h0, trp::NEG_PINS}, sw.rd & 32'h7FF);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check_pins("rereset out", trp::RST_OUT, tout);
    check_pins("rereset oe_n", trp::RST_OE_N, pad.oe_n);
    $display("test registers done");
    final_report();
  end
endmodule
`default_nettype wire
